/* File: include/fdt_pkg.sv */
package fdt_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W   = 8;
	localparam int unsigned ADR_W   = 8;
	localparam int unsigned DAT_W   = 32;
	localparam int unsigned SEL_W   = 4;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_RELOAD = 8'h04;
	localparam logic [7:0] ADDR_COUNT  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_MASK   = 8'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_MODE_BIT = 1;
	localparam int unsigned CTRL_OVF_BIT  = 2;
	localparam int unsigned STAT_OVF_BIT  = 0;
	localparam int unsigned WE_LANE       = 0;

	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic       EN_RST     = 1'b0;
	localparam logic       MODE_RST   = 1'b0;
	localparam logic       OVF_RST    = 1'b0;
	localparam logic       MASK_RST   = 1'b0;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [7:0] COUNT_RST  = 8'h00;
	localparam logic [7:0] COUNT_MAX  = 8'hff;

endpackage : fdt_pkg

/* File: rtl/fdt_sync3.sv */
`timescale 1ns/1ns
module fdt_sync3 (
	// clock, enable and reset
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic ce,
	// pin side
	input  wire logic din,
	// filtered side
	output logic      rise
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;

	// ----------------------------------------------------------------
	// three-stage capture, s1 feeds only s2
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else if (ce) begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// accepted level moves only when stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lvl_reg <= 1'b0;
			rise    <= 1'b0;
		end else if (ce) begin
			if (s2_reg == s3_reg) begin
				lvl_reg <= s3_reg;
			end
			rise <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
		end
	end

endmodule : fdt_sync3

/* File: rtl/fdt_timer.sv */
`timescale 1ns/1ns
module fdt_timer (
	// clock, enable, reset
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        arst_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// divider input clock pin
	input  wire logic        div_clk_in,
	// timer outputs
	output logic             divided_output_clock,
	output logic             baud_gen_enable,
	output logic             irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic       divider_enable;
	logic       normal_mode_select;
	logic       divider_overflow_flag;
	logic       ovf_mask_reg;
	logic [7:0] divider_reload_reg;
	logic [7:0] divider_count_reg;
	logic       tick;
	logic       run;
	logic       ovf;
	logic       req;
	logic       wr;
	logic       start;
	logic       flag_clr;
	logic [7:0] rd_next;

	// address match helper
	function automatic logic fdt_hit(input logic [7:0] adr, input logic [7:0] off);
		fdt_hit = (adr[7:2] == off[7:2]);
	endfunction : fdt_hit

	// ----------------------------------------------------------------
	// input clock pulse from the pin
	// ----------------------------------------------------------------
	fdt_sync3 u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.ce     (ce),
		.din    (div_clk_in),
		.rise   (tick)
	);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr       = req && wb_we_i && wb_sel_i[fdt_pkg::WE_LANE];
	assign run      = divider_enable && normal_mode_select;
	assign ovf      = ce && run && tick && (divider_count_reg == fdt_pkg::COUNT_MAX);
	assign start    = wr && fdt_hit(wb_adr_i, fdt_pkg::ADDR_CTRL)
		&& wb_dat_i[fdt_pkg::CTRL_EN_BIT] && wb_dat_i[fdt_pkg::CTRL_MODE_BIT] && !run;
	assign flag_clr = wr && fdt_hit(wb_adr_i, fdt_pkg::ADDR_STATUS)
		&& wb_dat_i[fdt_pkg::STAT_OVF_BIT];

	// one-cycle ack per request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
		end else if (ce) begin
			wb_ack_o <= req;
		end
	end

	// read mux, unmapped reads return zero
	always_comb begin
		rd_next = 8'h00;
		if (fdt_hit(wb_adr_i, fdt_pkg::ADDR_CTRL)) begin
			rd_next[fdt_pkg::CTRL_EN_BIT]   = divider_enable;
			rd_next[fdt_pkg::CTRL_MODE_BIT] = normal_mode_select;
			rd_next[fdt_pkg::CTRL_OVF_BIT]  = divider_overflow_flag;
		end else if (fdt_hit(wb_adr_i, fdt_pkg::ADDR_RELOAD)) begin
			rd_next = divider_reload_reg;
		end else if (fdt_hit(wb_adr_i, fdt_pkg::ADDR_COUNT)) begin
			rd_next = divider_count_reg;
		end else if (fdt_hit(wb_adr_i, fdt_pkg::ADDR_STATUS)) begin
			rd_next[fdt_pkg::STAT_OVF_BIT] = divider_overflow_flag;
		end else if (fdt_hit(wb_adr_i, fdt_pkg::ADDR_MASK)) begin
			rd_next[fdt_pkg::STAT_OVF_BIT] = ovf_mask_reg;
		end
	end

	// registered read data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce && req) begin
			wb_dat_o <= {24'h00_0000, rd_next};
		end
	end

	// ----------------------------------------------------------------
	// control and configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divider_enable     <= fdt_pkg::EN_RST;
			normal_mode_select <= fdt_pkg::MODE_RST;
		end else if (ce && wr && fdt_hit(wb_adr_i, fdt_pkg::ADDR_CTRL)) begin
			divider_enable     <= wb_dat_i[fdt_pkg::CTRL_EN_BIT];
			normal_mode_select <= wb_dat_i[fdt_pkg::CTRL_MODE_BIT];
		end
	end

	// reload value
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divider_reload_reg <= fdt_pkg::RELOAD_RST;
		end else if (ce && wr && fdt_hit(wb_adr_i, fdt_pkg::ADDR_RELOAD)) begin
			divider_reload_reg <= wb_dat_i[7:0];
		end
	end

	// interrupt mask
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ovf_mask_reg <= fdt_pkg::MASK_RST;
		end else if (ce && wr && fdt_hit(wb_adr_i, fdt_pkg::ADDR_MASK)) begin
			ovf_mask_reg <= wb_dat_i[fdt_pkg::STAT_OVF_BIT];
		end
	end

	// baud clocking only outside normal mode
	assign baud_gen_enable = divider_enable && !normal_mode_select;

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divider_count_reg <= fdt_pkg::COUNT_RST;
		end else if (ce) begin
			if (start) begin
				divider_count_reg <= divider_reload_reg;
			end else if (ovf) begin
				divider_count_reg <= divider_reload_reg;
			end else if (run && tick) begin
				divider_count_reg <= divider_count_reg + 8'h01;
			end
		end
	end

	// overflow flag, set beats a same-cycle clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divider_overflow_flag <= fdt_pkg::OVF_RST;
		end else if (ce) begin
			if (ovf) begin
				divider_overflow_flag <= 1'b1;
			end else if (flag_clr) begin
				divider_overflow_flag <= 1'b0;
			end
		end
	end

	// level interrupt from unmasked flag
	assign irq = divider_overflow_flag && ovf_mask_reg;

	// output clock: high from overflow to next counted input
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divided_output_clock <= 1'b0;
		end else if (ce) begin
			if (ovf) begin
				divided_output_clock <= 1'b1;
			end else if (!run || tick) begin
				divided_output_clock <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	bus_ack_a: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o || !ce)
		else $error("ack not a single cycle after request");
	baud_off_a: assert property (@(posedge clk) disable iff (!arst_n)
		normal_mode_select |-> !baud_gen_enable)
		else $error("baud clock active in normal mode");
	count_inc_a: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && run && tick && !start && divider_count_reg != fdt_pkg::COUNT_MAX)
		|=> divider_count_reg == $past(divider_count_reg) + 8'h01)
		else $error("counter did not advance by one");
	count_read_a: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && req && !wb_we_i && fdt_hit(wb_adr_i, fdt_pkg::ADDR_COUNT))
		|=> wb_ack_o && wb_dat_o[7:0] == $past(divider_count_reg))
		else $error("count read returned stale value");
	ovf_reload_a: assert property (@(posedge clk) disable iff (!arst_n)
		ovf |=> divider_count_reg == $past(divider_reload_reg))
		else $error("counter not reloaded on overflow");
	ovf_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
		(ovf && ovf_mask_reg) |=> divider_overflow_flag && irq)
		else $error("overflow did not flag and interrupt");
	out_clock_a: assert property (@(posedge clk) disable iff (!arst_n)
		ovf |=> divided_output_clock and ((!ce || (run && !tick)) |=> divided_output_clock))
		else $error("output clock period wrong");
	hold_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
		(!divider_enable && !start) |=> $stable(divider_count_reg) && !divided_output_clock)
		else $error("disabled counter moved");
	flag_clr_a: assert property (@(posedge clk) disable iff (!arst_n)
		(ce && flag_clr && !ovf) |=> !divider_overflow_flag)
		else $error("overflow flag not cleared");

endmodule : fdt_timer

/* File: test/tb.sv */
`timescale 1ns/1ns
module tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk = 1'b0;
	logic        ce = 1'b1;
	logic        arst_n = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        div_clk_in = 1'b0;
	logic        divided_output_clock;
	logic        baud_gen_enable;
	logic        irq;
	logic        prev_oc = 1'b0;
	int          errors = 0;
	int          num_checks = 0;
	int          seed = 16;
	int          cnt_m, rel_m, flag_m, mask_m, en_m, mode_m, ovf_m, oc_edges;
	// ----------------------------------------------------------------
	// design and clock
	// ----------------------------------------------------------------
	fdt_timer u_fdt_timer (.clk(clk), .ce(ce), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .div_clk_in(div_clk_in), .divided_output_clock(divided_output_clock),
		.baud_gen_enable(baud_gen_enable), .irq(irq));
	always #20 clk = ~clk;
	// counts rising edges of the divided clock
	always @(posedge clk) begin
		if (divided_output_clock === 1'b1 && prev_oc !== 1'b1) oc_edges++;
		prev_oc <= divided_output_clock;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// one classic cycle, held until ack, then one idle cycle
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
		output logic [31:0] rd);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (wb_ack_o === 1'b1) break;
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (i == 50) begin
			errors++;
			tally_and_finish();
		end
		@(posedge clk);
	endtask : wb
	task rd_chk(input string name, input logic [7:0] adr, input int exp);
		logic [31:0] d;
		wb(1'b0, adr, 32'h0, 4'hf, d);
		check(name, d, exp[31:0]);
	endtask : rd_chk
	task wr(input logic [7:0] adr, input int dat);
		logic [31:0] d;
		wb(1'b1, adr, dat[31:0], 4'hf, d);
	endtask : wr
	// control write, model loads count on start
	task ctrl_w(input int v);
		if ((v & 3) == 3 && !(en_m && mode_m)) cnt_m = rel_m;
		en_m = v & 1;
		mode_m = (v >> 1) & 1;
		wr(fdt_pkg::ADDR_CTRL, v);
	endtask : ctrl_w
	// input pulses, 4 cycles high and 4 low
	task pulse(input int n);
		repeat (n) begin
			div_clk_in <= 1'b1;
			repeat (4) @(posedge clk);
			div_clk_in <= 1'b0;
			repeat (4) @(posedge clk);
			if (en_m && mode_m) begin
				if (cnt_m == 255) begin
					cnt_m = rel_m;
					flag_m = 1;
					ovf_m++;
				end else cnt_m++;
			end
		end
	endtask : pulse
	task regs;
		rd_chk("ctrl", fdt_pkg::ADDR_CTRL, en_m | (mode_m << 1) | (flag_m << 2));
		rd_chk("count", fdt_pkg::ADDR_COUNT, cnt_m);
		rd_chk("status", fdt_pkg::ADDR_STATUS, flag_m);
		check("irq", irq, flag_m & mask_m);
		check("baud", baud_gen_enable, en_m & ~mode_m);
		check("oc_edges", oc_edges, ovf_m);
	endtask : regs
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		{cnt_m, rel_m, flag_m, mask_m, en_m, mode_m, ovf_m, oc_edges} = '0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		regs();
		rd_chk("reload", fdt_pkg::ADDR_RELOAD, 0);
		rd_chk("mask", fdt_pkg::ADDR_MASK, 0);
		rd_chk("unmapped", 8'h14, 0);
		rel_m = 8'hf0 | ($random(seed) & 7);
		wb(1'b1, fdt_pkg::ADDR_RELOAD, rel_m, 4'he, d);
		rd_chk("reload_nosel", fdt_pkg::ADDR_RELOAD, 0);
		wr(fdt_pkg::ADDR_RELOAD, rel_m);
		rd_chk("reload", fdt_pkg::ADDR_RELOAD, rel_m);
		ctrl_w(1);
		pulse(3);
		regs();
		ctrl_w(3);
		regs();
		// a full pin pulse while the clock enable is low must not count
		ce <= 1'b0;
		div_clk_in <= 1'b1;
		repeat (8) @(posedge clk);
		div_clk_in <= 1'b0;
		repeat (8) @(posedge clk);
		ce <= 1'b1;
		repeat (8) @(posedge clk);
		regs();
		pulse(5);
		regs();
		pulse(256 - rel_m - 5);
		regs();
		wr(fdt_pkg::ADDR_MASK, 1);
		mask_m = 1;
		regs();
		wr(fdt_pkg::ADDR_STATUS, 1);
		flag_m = 0;
		regs();
		pulse(2 * (256 - rel_m) + 1);
		regs();
		ctrl_w(2);
		pulse(20);
		regs();
		tally_and_finish();
	end
endmodule : tb
